// [core/mscp_pkg.sv]
// Purpose: Shared constants for the statistics counter part
// Assumes: 40 MHz system clock
// Notes: Counter widths and bin limits live here
package mscp_pkg;
   // ***********************************************
   // Widths
   // ***********************************************
   localparam int MSCP_BIN_W = 20;
   localparam int MSCP_WIDE_W = 32;
   localparam int MSCP_LEN_W = 16;
   localparam int MSCP_COL_W = 5;
   // ***********************************************
   // Frame length bins
   // ***********************************************
   localparam logic [MSCP_LEN_W-1:0] MSCP_BIN_A_LO = 16'h0200;
   localparam logic [MSCP_LEN_W-1:0] MSCP_BIN_A_HI = 16'h03ff;
   localparam logic [MSCP_LEN_W-1:0] MSCP_BIN_B_LO = 16'h0400;
   localparam logic [MSCP_LEN_W-1:0] MSCP_BIN_B_HI = 16'h05ee;
   // ***********************************************
   // Deferral
   // ***********************************************
   localparam logic [MSCP_LEN_W-1:0] MSCP_DEFER_MARGIN = 16'h0010;
   localparam int MSCP_BITS_PER_BYTE = 8;
   // ***********************************************
   // Time base
   // ***********************************************
   localparam int MSCP_CLK_MHZ = 40;
   localparam int MSCP_US_NS = 1000;
   localparam int MSCP_CLK_NS = 25;
   localparam int MSCP_US_CYCLES = MSCP_US_NS / MSCP_CLK_NS;
   localparam logic [MSCP_BIN_W-1:0] MSCP_BIN_RST = 20'h00000;
   localparam logic [MSCP_WIDE_W-1:0] MSCP_WIDE_RST = 32'h00000000;
endpackage

// [core/mscp_counter.sv]
// Purpose: Wrapping counter with clear and variable step
// Assumes: Synchronous active high reset
// Notes: Wraps past its maximum
`timescale 1ns/1ps
module mscp_counter #(
   parameter int W = 20
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clr,
   input wire logic inc,
   input wire logic [W-1:0] step,
   output logic [W-1:0] count
);
   logic [W-1:0] count_q;
   logic [W-1:0] count_d;
   // Wrap is free: the sum is cut to W bits
   assign count_d = clr ? '0 : (inc ? W'(count_q + step) : count_q);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end
   assign count = count_q;
endmodule // mscp_counter

// [core/mscp_sync.sv]
// Purpose: Three flop synchroniser with agreement filter
// Assumes: Input from outside the clock domain
// Notes: Output changes once stages two and three agree
`timescale 1ns/1ps
module mscp_sync (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic din,
   output logic dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic out_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            out_q <= s3_q;
         end
      end
   end
   assign dout = out_q;
endmodule // mscp_sync

// [core/mscp_stats.sv]
// Purpose: Upper receive bins, receive low-power-idle and transmit error counters
// Assumes: Frame events are one-cycle pulses from MAC logic on clk
// Notes: Counter read-out path lies outside this block
//
// Behaviour
// - Count good received frames of 512 to 1023 bytes.
// - Count good received frames of 1024 to 1518 bytes.
// - Count good received frames longer than 1518 bytes.
// - Bins skip frames failing address filter or dropped on FIFO overflow.
// - 32-bit count of rising edges of the PHY low-power-idle indication.
// - 32-bit microsecond total of time the PHY indicates low-power idle.
// - Both low-power-idle counters held clear while enable bit is low.
// - Low-power-idle counters keep running in sleep states zero, three, normal.
// - Count transmitted frames with a wrong frame check sequence.
// - Force-bad-checksum makes frames go out corrupted, and they are counted.
// - Count frames deferred over two max-frame times plus 16 bytes.
// - Deferral timer restarts from zero on each new deferral.
// - Count frames sent with carrier absent or lost.
// - Sum bytes of transmissions that ended in error.
// - Count frames sent successfully after exactly one collision.
// - Count frames sent successfully after more than one collision.
// - Upper receive bins are 20 bits wide.
`timescale 1ns/1ps
module mscp_stats
   import mscp_pkg::*;
#(
   parameter int US_CYCLES = mscp_pkg::MSCP_US_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic energy_efficient_enable,
   input wire logic force_bad_checksum,
   input wire logic [mscp_pkg::MSCP_LEN_W-1:0] max_frame_size,
   input wire logic sleep_state_zero,
   input wire logic sleep_state_three,
   input wire logic phy_rx_lpi,
   input wire logic rx_done,
   input wire logic rx_err,
   input wire logic rx_filter_fail,
   input wire logic rx_fifo_ovf,
   input wire logic [mscp_pkg::MSCP_LEN_W-1:0] rx_len,
   input wire logic tx_defer_active,
   input wire logic tx_bit_tick,
   input wire logic tx_done,
   input wire logic tx_ok,
   input wire logic tx_fcs_bad,
   input wire logic tx_carrier_lost,
   input wire logic [mscp_pkg::MSCP_LEN_W-1:0] tx_len,
   input wire logic [mscp_pkg::MSCP_COL_W-1:0] tx_collisions,
   output logic tx_fcs_corrupt,
   output logic [mscp_pkg::MSCP_BIN_W-1:0] rx_bin_512_cnt,
   output logic [mscp_pkg::MSCP_BIN_W-1:0] rx_bin_1024_cnt,
   output logic [mscp_pkg::MSCP_BIN_W-1:0] rx_bin_over_cnt,
   output logic [mscp_pkg::MSCP_WIDE_W-1:0] rx_lpi_trans_cnt,
   output logic [mscp_pkg::MSCP_WIDE_W-1:0] rx_lpi_time_cnt,
   output logic [mscp_pkg::MSCP_BIN_W-1:0] tx_fcs_err_cnt,
   output logic [mscp_pkg::MSCP_BIN_W-1:0] tx_defer_err_cnt,
   output logic [mscp_pkg::MSCP_BIN_W-1:0] tx_carrier_err_cnt,
   output logic [mscp_pkg::MSCP_WIDE_W-1:0] tx_bad_byte_cnt,
   output logic [mscp_pkg::MSCP_BIN_W-1:0] tx_single_col_cnt,
   output logic [mscp_pkg::MSCP_BIN_W-1:0] tx_multi_col_cnt
);
   import mscp_pkg::*;
   localparam int DW = MSCP_WIDE_W;
   localparam int BW = MSCP_BIN_W;
   localparam logic [BW-1:0] ONE_B = 20'h00001;
   localparam logic [DW-1:0] ONE_W = 32'h00000001;

   // ***********************************************
   // Receive length bins
   // ***********************************************
   logic rx_good;
   logic in_a;
   logic in_b;
   logic in_over;
   assign rx_good = rx_done & ~rx_err & ~rx_filter_fail & ~rx_fifo_ovf;
   assign in_a = rx_good && rx_len >= MSCP_BIN_A_LO && rx_len <= MSCP_BIN_A_HI;
   assign in_b = rx_good && rx_len >= MSCP_BIN_B_LO && rx_len <= MSCP_BIN_B_HI;
   assign in_over = rx_good && rx_len > MSCP_BIN_B_HI;

   mscp_counter #(.W(BW)) u_bin_a (.clk(clk), .sys_rst(sys_rst), .clr(1'b0),
      .inc(in_a), .step(ONE_B), .count(rx_bin_512_cnt));
   mscp_counter #(.W(BW)) u_bin_b (.clk(clk), .sys_rst(sys_rst), .clr(1'b0),
      .inc(in_b), .step(ONE_B), .count(rx_bin_1024_cnt));
   mscp_counter #(.W(BW)) u_bin_o (.clk(clk), .sys_rst(sys_rst), .clr(1'b0),
      .inc(in_over), .step(ONE_B), .count(rx_bin_over_cnt));

   // ***********************************************
   // Receive low-power idle
   // ***********************************************
   // Sleep state inputs are deliberately not used as gates: counting
   // must not stop in any of the listed power states
   logic lpi_s;
   logic lpi_prev_q;
   logic lpi_rise;
   logic lpi_clr;
   logic us_tick;
   logic [15:0] us_div_q;
   logic [15:0] us_div_d;
   logic unused_sleep;
   assign unused_sleep = sleep_state_zero | sleep_state_three;

   mscp_sync u_lpi_sync (.clk(clk), .sys_rst(sys_rst), .din(phy_rx_lpi), .dout(lpi_s));

   assign lpi_clr = ~energy_efficient_enable;
   assign lpi_rise = lpi_s & ~lpi_prev_q;
   // Microsecond prescaler runs only while idle is indicated
   assign us_tick = lpi_s && (us_div_q == 16'(US_CYCLES - 1));
   assign us_div_d = (lpi_clr || !lpi_s || us_tick) ? 16'h0000 : 16'(us_div_q + 16'h0001);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lpi_prev_q <= 1'b0;
         us_div_q <= 16'h0000;
      end else begin
         lpi_prev_q <= lpi_s;
         us_div_q <= us_div_d;
      end
   end

   mscp_counter #(.W(DW)) u_lpi_tr (.clk(clk), .sys_rst(sys_rst), .clr(lpi_clr),
      .inc(lpi_rise), .step(ONE_W), .count(rx_lpi_trans_cnt));
   mscp_counter #(.W(DW)) u_lpi_tm (.clk(clk), .sys_rst(sys_rst), .clr(lpi_clr),
      .inc(us_tick), .step(ONE_W), .count(rx_lpi_time_cnt));

   // ***********************************************
   // Transmit errors
   // ***********************************************
   logic fcs_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fcs_q <= 1'b0;
      end else begin
         fcs_q <= force_bad_checksum;
      end
   end
   assign tx_fcs_corrupt = fcs_q;

   logic fcs_err;
   assign fcs_err = tx_done & (tx_fcs_bad | fcs_q);
   mscp_counter #(.W(BW)) u_fcs (.clk(clk), .sys_rst(sys_rst), .clr(1'b0),
      .inc(fcs_err), .step(ONE_B), .count(tx_fcs_err_cnt));

   // Deferral limit in bit times: two max frames plus margin
   logic [DW-1:0] defer_lim;
   logic [DW-1:0] defer_q;
   logic [DW-1:0] defer_d;
   logic defer_act_q;
   logic defer_over_q;
   logic defer_over_d;
   logic defer_err;
   assign defer_lim = DW'((2 * {16'h0000, max_frame_size} + {16'h0000, MSCP_DEFER_MARGIN})
      * MSCP_BITS_PER_BYTE);
   logic defer_fresh;
   assign defer_fresh = tx_defer_active && !defer_act_q;
   // A fresh deferral restarts the timer and counts its own first bit time;
   // end of transmission clears it so a later frame is not judged on old deferral
   assign defer_d = defer_fresh ? {31'h00000000, tx_bit_tick} :
      (tx_done ? 32'h00000000 :
      ((tx_defer_active && tx_bit_tick && defer_q != 32'hffffffff) ?
      DW'(defer_q + ONE_W) : defer_q));
   assign defer_over_d = tx_done ? 1'b0 : (defer_over_q | (defer_q > defer_lim));
   assign defer_err = tx_done & (defer_over_q | (defer_q > defer_lim));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         defer_q <= MSCP_WIDE_RST;
         defer_act_q <= 1'b0;
         defer_over_q <= 1'b0;
      end else begin
         defer_q <= defer_d;
         defer_act_q <= tx_defer_active;
         defer_over_q <= defer_over_d;
      end
   end
   mscp_counter #(.W(BW)) u_defer (.clk(clk), .sys_rst(sys_rst), .clr(1'b0),
      .inc(defer_err), .step(ONE_B), .count(tx_defer_err_cnt));

   logic car_err;
   assign car_err = tx_done & tx_carrier_lost;
   mscp_counter #(.W(BW)) u_car (.clk(clk), .sys_rst(sys_rst), .clr(1'b0),
      .inc(car_err), .step(ONE_B), .count(tx_carrier_err_cnt));

   logic tx_bad;
   assign tx_bad = tx_done & ~tx_ok;
   mscp_counter #(.W(DW)) u_bad (.clk(clk), .sys_rst(sys_rst), .clr(1'b0),
      .inc(tx_bad), .step({16'h0000, tx_len}), .count(tx_bad_byte_cnt));

   logic col_one;
   logic col_many;
   assign col_one = tx_done & tx_ok & (tx_collisions == 5'h01);
   assign col_many = tx_done & tx_ok & (tx_collisions > 5'h01);
   mscp_counter #(.W(BW)) u_sc (.clk(clk), .sys_rst(sys_rst), .clr(1'b0),
      .inc(col_one), .step(ONE_B), .count(tx_single_col_cnt));
   mscp_counter #(.W(BW)) u_mc (.clk(clk), .sys_rst(sys_rst), .clr(1'b0),
      .inc(col_many), .step(ONE_B), .count(tx_multi_col_cnt));

   // ***********************************************
   // Checks
   // ***********************************************
   a_bin_a_count: assert property (@(posedge clk) disable iff (sys_rst)
      in_a |=> rx_bin_512_cnt == BW'($past(rx_bin_512_cnt) + ONE_B))
      else $error("512 bin missed");
   a_bin_b_count: assert property (@(posedge clk) disable iff (sys_rst)
      in_b |=> rx_bin_1024_cnt == BW'($past(rx_bin_1024_cnt) + ONE_B))
      else $error("1024 bin missed");
   a_bin_over_count: assert property (@(posedge clk) disable iff (sys_rst)
      in_over |=> rx_bin_over_cnt == BW'($past(rx_bin_over_cnt) + ONE_B))
      else $error("oversize bin missed");
   a_bin_filter_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (rx_filter_fail || rx_fifo_ovf) |=> $stable(rx_bin_512_cnt)
      && $stable(rx_bin_1024_cnt) && $stable(rx_bin_over_cnt))
      else $error("bin counted a dropped frame");
   a_lpi_edge_count: assert property (@(posedge clk) disable iff (sys_rst)
      (lpi_rise && energy_efficient_enable) |=>
      rx_lpi_trans_cnt == DW'($past(rx_lpi_trans_cnt) + ONE_W))
      else $error("idle edge not counted");
   a_lpi_clear_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !energy_efficient_enable |=> rx_lpi_trans_cnt == 32'h0 && rx_lpi_time_cnt == 32'h0)
      else $error("idle counters not clear");
   a_fcs_forced: assert property (@(posedge clk) disable iff (sys_rst)
      (tx_done && fcs_q) |=> tx_fcs_err_cnt == BW'($past(tx_fcs_err_cnt) + ONE_B))
      else $error("forced bad checksum not counted");
   a_col_single: assert property (@(posedge clk) disable iff (sys_rst)
      (tx_done && tx_ok && tx_collisions == 5'h01) |=>
      tx_single_col_cnt != $past(tx_single_col_cnt) && $stable(tx_multi_col_cnt))
      else $error("single collision miscounted");
   a_defer_restart: assert property (@(posedge clk) disable iff (sys_rst)
      (tx_defer_active && !defer_act_q) |=> defer_q == {31'h00000000, $past(tx_bit_tick)})
      else $error("deferral timer not restarted");

   // ***********************************************
   // Checks: idle entry and time counters, transmit counters
   // ***********************************************
   // Idle entry takes two steps on the synchronised pin
   sequence s_lpi_enter;
      !lpi_s ##1 (lpi_s && energy_efficient_enable);
   endsequence
   sequence s_idle_tick;
      (lpi_s && energy_efficient_enable) ##0 us_tick;
   endsequence
   a_lpi_enter_count: assert property (@(posedge clk) disable iff (sys_rst)
      s_lpi_enter |=>
      rx_lpi_trans_cnt == DW'($past(rx_lpi_trans_cnt) + ONE_W))
      else $error("idle entry not counted");
   a_lpi_time_step: assert property (@(posedge clk) disable iff (sys_rst)
      s_idle_tick |=>
      rx_lpi_time_cnt == DW'($past(rx_lpi_time_cnt) + ONE_W))
      else $error("idle microsecond not counted");
   a_lpi_time_idle: assert property (@(posedge clk) disable iff (sys_rst)
      (!lpi_s && energy_efficient_enable) |=>
      $stable(rx_lpi_time_cnt))
      else $error("idle time moved while not idle");
   a_us_period: assert property (@(posedge clk) disable iff (sys_rst)
      us_div_q < 16'(US_CYCLES))
      else $error("microsecond prescaler overran");
   a_lpi_sleep_run: assert property (@(posedge clk) disable iff (sys_rst)
      (us_tick && energy_efficient_enable && (sleep_state_zero || sleep_state_three)) |=>
      rx_lpi_time_cnt != $past(rx_lpi_time_cnt))
      else $error("idle time stopped in sleep state");
   a_fcs_count: assert property (@(posedge clk) disable iff (sys_rst)
      (tx_done && tx_fcs_bad) |=>
      tx_fcs_err_cnt == BW'($past(tx_fcs_err_cnt) + ONE_B))
      else $error("bad checksum not counted");
   a_fcs_follow: assert property (@(posedge clk) disable iff (sys_rst)
      force_bad_checksum |=> tx_fcs_corrupt)
      else $error("forced corruption not applied");
   a_fcs_release: assert property (@(posedge clk) disable iff (sys_rst)
      !force_bad_checksum |=> !tx_fcs_corrupt)
      else $error("corruption applied while not forced");
   a_defer_count: assert property (@(posedge clk) disable iff (sys_rst)
      (tx_done && defer_over_q) |=>
      tx_defer_err_cnt == BW'($past(tx_defer_err_cnt) + ONE_B))
      else $error("excess deferral not counted");
   a_defer_quiet: assert property (@(posedge clk) disable iff (sys_rst)
      (tx_done && !defer_over_q && defer_q <= defer_lim) |=>
      $stable(tx_defer_err_cnt))
      else $error("short deferral counted");
   a_carrier_count: assert property (@(posedge clk) disable iff (sys_rst)
      (tx_done && tx_carrier_lost) |=>
      tx_carrier_err_cnt == BW'($past(tx_carrier_err_cnt) + ONE_B))
      else $error("carrier error not counted");
   a_bad_bytes: assert property (@(posedge clk) disable iff (sys_rst)
      (tx_done && !tx_ok) |=>
      tx_bad_byte_cnt == DW'($past(tx_bad_byte_cnt) + {16'h0000, $past(tx_len)}))
      else $error("bad bytes not added");
   a_col_multi: assert property (@(posedge clk) disable iff (sys_rst)
      (tx_done && tx_ok && tx_collisions > 5'h01) |=>
      tx_multi_col_cnt == BW'($past(tx_multi_col_cnt) + ONE_B) && $stable(tx_single_col_cnt))
      else $error("multiple collision miscounted");
   a_col_failed: assert property (@(posedge clk) disable iff (sys_rst)
      (tx_done && !tx_ok) |=>
      $stable(tx_single_col_cnt) && $stable(tx_multi_col_cnt))
      else $error("failed frame counted as collision success");
endmodule // mscp_stats

// [sim/mscp_phy_model.sv]
// Purpose: Far-side PHY model driving the receive low-power-idle indication
// Assumes: Bench asks for idle by holding lpi_req high
// Notes: Pin moves a fixed 7 ns after the request, so it lands off the clk edge
`timescale 1ns/1ps
module mscp_phy_model (
   input wire logic lpi_req,
   output logic phy_rx_lpi
);
   // ***********************************************
   // Idle indication
   // ***********************************************
   // Offset keeps the pin off the MAC clock edge, as a real PHY would be
   assign #7 phy_rx_lpi = lpi_req;
endmodule // mscp_phy_model

// [sim/test_mscp_stats.sv]
// Purpose: Self-checking bench for the statistics counter part
// Assumes: Prescaler shortened to 4 cycles per microsecond
// Notes: Counter wrap is left to the design's own assertions
`timescale 1ns/1ps
module test_mscp_stats;
   import mscp_pkg::*;
   localparam int US = 4;
   localparam logic [15:0] LENS [10] = '{16'h01ff, 16'h0200, 16'h03ff, 16'h0400, 16'h05ee,
      16'h05ef, 16'h2328, 16'h0258, 16'h044c, 16'h07d0};
   logic clk = 1'b0, sys_rst = 1'b1, energy_efficient_enable = 1'b0, force_bad_checksum = 1'b0;
   logic sleep_state_zero = 1'b0, sleep_state_three = 1'b0, lpi_req = 1'b0, phy_rx_lpi;
   logic rx_done = 1'b0, rx_err = 1'b0, rx_filter_fail = 1'b0, rx_fifo_ovf = 1'b0;
   logic tx_defer_active = 1'b0, tx_bit_tick = 1'b0, tx_done = 1'b0, tx_ok = 1'b0;
   logic tx_fcs_bad = 1'b0, tx_carrier_lost = 1'b0, tx_fcs_corrupt;
   logic [15:0] max_frame_size = 16'h0004, rx_len = 16'h0000, tx_len = 16'h0000;
   logic [4:0] tx_collisions = 5'h00;
   logic [19:0] rx_bin_512_cnt, rx_bin_1024_cnt, rx_bin_over_cnt, tx_fcs_err_cnt;
   logic [19:0] tx_defer_err_cnt, tx_carrier_err_cnt, tx_single_col_cnt, tx_multi_col_cnt;
   logic [31:0] rx_lpi_trans_cnt, rx_lpi_time_cnt, tx_bad_byte_cnt;
   int fail_count = 0;
   int n_compared = 0;
   // ***********************************************
   // Clock, partner and design
   // ***********************************************
   initial begin
      forever #12.5 clk = ~clk;
   end
   mscp_phy_model phy (.lpi_req(lpi_req), .phy_rx_lpi(phy_rx_lpi));
   mscp_stats #(.US_CYCLES(US)) DUT (.clk, .sys_rst, .energy_efficient_enable,
      .force_bad_checksum, .max_frame_size, .sleep_state_zero, .sleep_state_three,
      .phy_rx_lpi, .rx_done, .rx_err, .rx_filter_fail, .rx_fifo_ovf, .rx_len,
      .tx_defer_active, .tx_bit_tick, .tx_done, .tx_ok, .tx_fcs_bad, .tx_carrier_lost,
      .tx_len, .tx_collisions, .tx_fcs_corrupt, .rx_bin_512_cnt, .rx_bin_1024_cnt,
      .rx_bin_over_cnt, .rx_lpi_trans_cnt, .rx_lpi_time_cnt, .tx_fcs_err_cnt,
      .tx_defer_err_cnt, .tx_carrier_err_cnt, .tx_bad_byte_cnt, .tx_single_col_cnt,
      .tx_multi_col_cnt);
   // ***********************************************
   // Tasks
   // ***********************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: %s saw %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Frame tasks leave the strobe up so calls can run back to back; settle drops it
   task automatic rx_frame(input logic [15:0] len, input logic e, input logic f, input logic o);
      rx_done <= 1'b1;
      rx_len <= len;
      rx_err <= e;
      rx_filter_fail <= f;
      rx_fifo_ovf <= o;
      @(posedge clk);
   endtask
   task automatic tx_frame(input logic ok, input logic fcs, input logic car,
      input logic [15:0] len, input logic [4:0] col);
      tx_done <= 1'b1;
      tx_ok <= ok;
      tx_fcs_bad <= fcs;
      tx_carrier_lost <= car;
      tx_len <= len;
      tx_collisions <= col;
      @(posedge clk);
   endtask
   task automatic settle;
      rx_done <= 1'b0;
      tx_done <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic defer(input int n);
      tx_defer_active <= 1'b1;
      tx_bit_tick <= 1'b1;
      repeat (n) @(posedge clk);
      tx_defer_active <= 1'b0;
      tx_bit_tick <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic idle_burst(input int n);
      lpi_req <= 1'b1;
      repeat (n) @(posedge clk);
      lpi_req <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   // ***********************************************
   // Sequence
   // ***********************************************
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      settle();
      check(rx_bin_512_cnt, 32'h0, "bin reset");
      check(tx_bad_byte_cnt, 32'h0, "bad byte reset");
      // Boundary lengths first, then refused frames at once after them
      for (int i = 0; i < 10; i++) begin
         rx_frame(LENS[i], i == 7, i == 8, i == 9);
      end
      settle();
      check(rx_bin_512_cnt, 32'h2, "bin 512");
      check(rx_bin_1024_cnt, 32'h2, "bin 1024");
      check(rx_bin_over_cnt, 32'h2, "bin over");
      tx_frame(1'b1, 1'b1, 1'b0, 16'h0040, 5'h00);
      tx_frame(1'b0, 1'b0, 1'b1, 16'h0064, 5'h00);
      tx_frame(1'b1, 1'b0, 1'b0, 16'h00c8, 5'h01);
      tx_frame(1'b1, 1'b0, 1'b0, 16'h012c, 5'h02);
      tx_frame(1'b0, 1'b0, 1'b0, 16'h0032, 5'h01);
      tx_frame(1'b1, 1'b0, 1'b0, 16'h0190, 5'h0f);
      settle();
      force_bad_checksum <= 1'b1;
      repeat (2) @(posedge clk);
      check(tx_fcs_corrupt, 1'b1, "forced corrupt");
      tx_frame(1'b1, 1'b0, 1'b0, 16'h0040, 5'h00);
      settle();
      force_bad_checksum <= 1'b0;
      check(tx_fcs_err_cnt, 32'h2, "fcs errors");
      check(tx_carrier_err_cnt, 32'h1, "carrier errors");
      check(tx_bad_byte_cnt, 32'h96, "bad bytes");
      check(tx_single_col_cnt, 32'h1, "single col");
      check(tx_multi_col_cnt, 32'h2, "multi col");
      // Limit is (2*4+16)*8 = 192 bit times; two 150 spans must not add up
      defer(150);
      defer(150);
      tx_frame(1'b1, 1'b0, 1'b0, 16'h0040, 5'h00);
      settle();
      check(tx_defer_err_cnt, 32'h0, "defer restart");
      defer(192);
      tx_frame(1'b1, 1'b0, 1'b0, 16'h0040, 5'h00);
      settle();
      check(tx_defer_err_cnt, 32'h0, "defer at limit");
      defer(193);
      tx_frame(1'b1, 1'b0, 1'b0, 16'h0040, 5'h00);
      settle();
      check(tx_defer_err_cnt, 32'h1, "defer over");
      idle_burst(42);
      check(rx_lpi_trans_cnt, 32'h0, "idle while off");
      check(rx_lpi_time_cnt, 32'h0, "time while off");
      energy_efficient_enable <= 1'b1;
      sleep_state_zero <= 1'b1;
      @(posedge clk);
      idle_burst(42);
      check(rx_lpi_trans_cnt, 32'h1, "idle entries");
      check(rx_lpi_time_cnt, 32'h0a, "idle time");
      sleep_state_zero <= 1'b0;
      sleep_state_three <= 1'b1;
      @(posedge clk);
      idle_burst(22);
      check(rx_lpi_trans_cnt, 32'h2, "idle entries");
      check(rx_lpi_time_cnt, 32'h0f, "idle time");
      energy_efficient_enable <= 1'b0;
      repeat (3) @(posedge clk);
      check(rx_lpi_trans_cnt, 32'h0, "cleared entries");
      check(rx_lpi_time_cnt, 32'h0, "cleared time");
      close_out();
   end
endmodule // test_mscp_stats
